/* src/amp_diag_pkg.sv */
// Package with timing counts and encodings for the amplifier diagnostic sequencer
package amp_diag_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int CHECK_TIME_US = 1000;
    localparam int CHECK_CYCLES = (CLK_HZ / 1000000) * CHECK_TIME_US;
    localparam int DIAG_TIME_MS = 100;
    localparam int DIAG_CYCLES = (CLK_HZ / 1000) * DIAG_TIME_MS;
    localparam int SAFETY_TIME_MS = 40;
    localparam int SAFETY_CYCLES = (CLK_HZ / 1000) * SAFETY_TIME_MS;
    localparam int MIN_AC_PULSES = 3;
    // Instruction byte one fields
    localparam int IB1_UNMUTE_REAR = 1;
    localparam int IB1_UNMUTE_FRONT = 2;
    localparam int IB1_LINE_DIAG = 3;
    localparam int IB1_DIAG_EN = 4;
    localparam int IB1_OFFSET_EN = 5;
    localparam int IB1_GAIN_LOW = 6;
    localparam int IB1_STANDBY_MUTE_PIN_OUT = 7;
    // Instruction byte two fields
    localparam int IB2_SAFETY_EN = 0;
    localparam int IB2_AC_EN = 2;
    localparam int IB2_AC_LOW_THR = 7;
    // Diag byte two safety shutdown flag
    localparam int DB2_SAFETY_BIT = 6;
    // Per-channel result fields
    localparam int RES_SHORT_GND = 0;
    localparam int RES_SHORT_VS = 1;
    localparam int RES_SHORT_LOAD = 2;
    localparam int RES_OPEN_LOAD = 3;
    localparam int RES_OFFSET = 4;
    localparam int RES_AC_OPEN = 5;
    localparam int RES_WIDTH = 6;
    typedef enum logic [2:0] {
        CH_IDLE, CH_ACTIVE, CH_CHECK, CH_DIAG, CH_RESTART
    } ch_state_t;
    typedef enum logic [1:0] {PULSE_IDLE, PULSE_RUN, PULSE_DONE} pulse_state_t;
endpackage

/* src/amp_fault_diag.sv */
// Diagnostic sequencer of a four-channel amplifier: turn-on, permanent, AC and offset
`timescale 1ns/1ps
// Behaviour
// - Turn-on result held; new pulse after read
// - Pulse first, outputs off during pulse
// - Then permanent diagnostics; result kept until short
// - Latch status at plateau end, 100 ms
// - Line-driver thresholds when low gain and option
// - Restart mode: fault shuts only its channel
// - Restart mode rechecks shut channel every 1 ms
// - Diag mode: recheck after 1 ms, resume
// - Overload persists: run 100 ms diagnostic cycle
// - After cycle: restart mode, store fault data
// - Next cycle only after host read
// - AC diagnostic active only when enabled
// - Threshold bit selects AC current levels
// - Fewer than 3 pulses reports open tweeter
// - Protection overload suppresses AC diagnostic
// - Flag offset beyond 2 V in play
// - Safety routine mutes on offset at power-on
// - Safety routine runs only when enabled
// - Offset found: mute within 40 ms
// - Safety shutdown shown in diag byte two
module amp_fault_diag #(
    parameter int CHANNELS = 4,
    parameter int DIAG_CYCLES = amp_diag_pkg::DIAG_CYCLES,
    parameter int CHECK_CYCLES = amp_diag_pkg::CHECK_CYCLES,
    parameter int SAFETY_CYCLES = amp_diag_pkg::SAFETY_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] instructionByteOne,
    input wire logic [7:0] instructionByteTwo,
    input wire logic instrWrite,
    input wire logic hostRead,
    input wire logic playMode,
    input wire logic [CHANNELS-1:0] scProtect,
    input wire logic [CHANNELS-1:0] shortGnd,
    input wire logic [CHANNELS-1:0] shortVs,
    input wire logic [CHANNELS-1:0] loadShortHigh,
    input wire logic [CHANNELS-1:0] loadShortLine,
    input wire logic [CHANNELS-1:0] loadOpenHigh,
    input wire logic [CHANNELS-1:0] loadOpenLine,
    input wire logic [CHANNELS-1:0] offsetHigh,
    input wire logic [CHANNELS-1:0] acPulseHigh,
    input wire logic [CHANNELS-1:0] acPulseLow,
    output logic [CHANNELS-1:0] channelOn,
    output logic powerStageOff,
    output logic pulseActive,
    output logic safetyMute,
    output logic [7:0] diagByteTwo,
    output logic [CHANNELS*amp_diag_pkg::RES_WIDTH-1:0] diagResults
);
    // Refuse counts that the shared timer width cannot hold
    if (CHANNELS < 1 || CHANNELS > 8 || DIAG_CYCLES < 2 || CHECK_CYCLES < 2
        || SAFETY_CYCLES < 1 || CHECK_CYCLES > DIAG_CYCLES
        || SAFETY_CYCLES > DIAG_CYCLES) begin : gBadParams
        $error("amp_fault_diag: unsupported parameter values");
    end

    localparam int CW = $clog2(DIAG_CYCLES + 1);
    localparam int RW = amp_diag_pkg::RES_WIDTH;

    // Decrement that stops at zero, used by all timers
    function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
        dec = (v == '0) ? '0 : v - CW'(1);
    endfunction

    logic [7:0] ib1_q;
    logic [7:0] ib2_q;
    logic stbyOut;
    logic diagEn;
    logic lineMode;
    logic acEn;
    logic acLowThr;
    logic safetyEn;
    logic [CHANNELS-1:0] loadShort;
    logic [CHANNELS-1:0] loadOpen;
    logic [CHANNELS-1:0] acPulse;

    // Instruction byte storage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ib1_q <= 8'h00;
            ib2_q <= 8'h00;
        end else if (instrWrite) begin
            ib1_q <= instructionByteOne;
            ib2_q <= instructionByteTwo;
        end
    end

    assign stbyOut = ib1_q[amp_diag_pkg::IB1_STANDBY_MUTE_PIN_OUT];
    assign diagEn = ib1_q[amp_diag_pkg::IB1_DIAG_EN];
    assign lineMode = ib1_q[amp_diag_pkg::IB1_GAIN_LOW] & ib1_q[amp_diag_pkg::IB1_LINE_DIAG];
    assign acEn = ib2_q[amp_diag_pkg::IB2_AC_EN];
    assign acLowThr = ib2_q[amp_diag_pkg::IB2_AC_LOW_THR];
    assign safetyEn = ib2_q[amp_diag_pkg::IB2_SAFETY_EN];
    // Load thresholds follow gain; ground and supply shorts do not
    assign loadShort = lineMode ? loadShortLine : loadShortHigh;
    assign loadOpen = lineMode ? loadOpenLine : loadOpenHigh;
    assign acPulse = acLowThr ? acPulseLow : acPulseHigh;

    // Turn-on pulse sequencer
    amp_diag_pkg::pulse_state_t pState_q;
    logic [CW-1:0] pCnt_q;
    logic pulseArmed_q;
    logic pulseEnd;

    assign pulseEnd = (pState_q == amp_diag_pkg::PULSE_RUN) && (pCnt_q == CW'(1));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pState_q <= amp_diag_pkg::PULSE_IDLE;
            pCnt_q <= '0;
        end else begin
            unique case (pState_q)
                amp_diag_pkg::PULSE_IDLE: begin
                    if (stbyOut && diagEn && pulseArmed_q) begin
                        pState_q <= amp_diag_pkg::PULSE_RUN;
                        pCnt_q <= CW'(DIAG_CYCLES);
                    end
                end
                amp_diag_pkg::PULSE_RUN: begin
                    pCnt_q <= dec(pCnt_q);
                    if (pulseEnd) begin
                        pState_q <= amp_diag_pkg::PULSE_DONE;
                    end
                end
                amp_diag_pkg::PULSE_DONE: begin
                    if (!stbyOut) begin
                        pState_q <= amp_diag_pkg::PULSE_IDLE;
                    end
                end
                default: pState_q <= amp_diag_pkg::PULSE_IDLE;
            endcase
        end
    end

    // Re-arm of the pulse only after a read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pulseArmed_q <= 1'b1;
        end else if (hostRead) begin
            pulseArmed_q <= 1'b1;
        end else if (pState_q == amp_diag_pkg::PULSE_RUN) begin
            pulseArmed_q <= 1'b0;
        end
    end

    // Power stage held off while pulse runs or before standby exit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pulseActive <= 1'b0;
            powerStageOff <= 1'b1;
        end else begin
            pulseActive <= (pState_q == amp_diag_pkg::PULSE_RUN);
            powerStageOff <= !stbyOut || (pState_q == amp_diag_pkg::PULSE_RUN)
                || (stbyOut && diagEn && pulseArmed_q
                    && pState_q == amp_diag_pkg::PULSE_IDLE);
        end
    end

    // Per-channel permanent diagnostic machines
    amp_diag_pkg::ch_state_t chState_q [CHANNELS];
    logic [CW-1:0] chCnt_q [CHANNELS];
    logic [CHANNELS-1:0] cycleDone_q;
    logic [RW-1:0] res_q [CHANNELS];
    logic [1:0] acCount_q [CHANNELS];
    logic [CHANNELS-1:0] acSuppress_q;
    logic [CHANNELS-1:0] offPersist_q;
    logic [CHANNELS-1:0] chOn;
    logic [CHANNELS*RW-1:0] diagResults_d;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gCh
            logic cycEnd;
            logic [RW-1:0] faultNow;
            assign cycEnd = (chState_q[g] == amp_diag_pkg::CH_DIAG) && (chCnt_q[g] == CW'(1));
            assign faultNow = {1'b0, 1'b0, 1'b0, loadShort[g], shortVs[g], shortGnd[g]};
            assign chOn[g] = (chState_q[g] == amp_diag_pkg::CH_ACTIVE);

            // Channel state: restart vs diagnostic mode
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    chState_q[g] <= amp_diag_pkg::CH_IDLE;
                    chCnt_q[g] <= '0;
                end else if (powerStageOff) begin
                    chState_q[g] <= amp_diag_pkg::CH_IDLE;
                    chCnt_q[g] <= '0;
                end else begin
                    chCnt_q[g] <= dec(chCnt_q[g]);
                    unique case (chState_q[g])
                        amp_diag_pkg::CH_IDLE: begin
                            chState_q[g] <= amp_diag_pkg::CH_ACTIVE;
                        end
                        amp_diag_pkg::CH_ACTIVE: begin
                            if (scProtect[g]) begin
                                chCnt_q[g] <= CW'(CHECK_CYCLES);
                                chState_q[g] <= (diagEn && !cycleDone_q[g])
                                    ? amp_diag_pkg::CH_CHECK : amp_diag_pkg::CH_RESTART;
                            end
                        end
                        amp_diag_pkg::CH_CHECK: begin
                            if (chCnt_q[g] == CW'(1)) begin
                                if (scProtect[g]) begin
                                    chState_q[g] <= amp_diag_pkg::CH_DIAG;
                                    chCnt_q[g] <= CW'(DIAG_CYCLES);
                                end else begin
                                    chState_q[g] <= amp_diag_pkg::CH_ACTIVE;
                                end
                            end
                        end
                        amp_diag_pkg::CH_DIAG: begin
                            if (cycEnd) begin
                                chState_q[g] <= amp_diag_pkg::CH_RESTART;
                                chCnt_q[g] <= CW'(CHECK_CYCLES);
                            end
                        end
                        amp_diag_pkg::CH_RESTART: begin
                            if (chCnt_q[g] == CW'(1)) begin
                                if (scProtect[g]) begin
                                    chCnt_q[g] <= CW'(CHECK_CYCLES);
                                end else begin
                                    chState_q[g] <= amp_diag_pkg::CH_ACTIVE;
                                end
                            end
                        end
                        default: chState_q[g] <= amp_diag_pkg::CH_IDLE;
                    endcase
                end
            end

            // Cycle done until a read re-arms it
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    cycleDone_q[g] <= 1'b0;
                end else if (cycEnd) begin
                    cycleDone_q[g] <= 1'b1;
                end else if (hostRead) begin
                    cycleDone_q[g] <= 1'b0;
                end
            end

            // AC pulse counting and, while AC is enabled, offset persistence over the measuring period
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    acCount_q[g] <= 2'h0;
                    acSuppress_q[g] <= 1'b0;
                    offPersist_q[g] <= 1'b1;
                end else if (hostRead || !acEn) begin
                    acCount_q[g] <= 2'h0;
                    acSuppress_q[g] <= acEn && scProtect[g];
                    offPersist_q[g] <= 1'b1;
                end else begin
                    if (acPulse[g] && acCount_q[g] != 2'(amp_diag_pkg::MIN_AC_PULSES)) begin
                        acCount_q[g] <= acCount_q[g] + 2'h1;
                    end
                    if (scProtect[g]) begin
                        acSuppress_q[g] <= 1'b1;
                    end
                    if (!offsetHigh[g]) begin
                        offPersist_q[g] <= 1'b0;
                    end
                end
            end

            // Result latch per channel
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    res_q[g] <= '0;
                end else begin
                    if (pulseEnd) begin
                        res_q[g] <= faultNow | RW'({loadOpen[g], 3'h0});
                    end else if (cycEnd) begin
                        res_q[g][amp_diag_pkg::RES_SHORT_LOAD:0] <= faultNow[2:0];
                    end
                    if (hostRead) begin
                        res_q[g][amp_diag_pkg::RES_AC_OPEN] <= acEn && !acSuppress_q[g]
                            && acCount_q[g] != 2'(amp_diag_pkg::MIN_AC_PULSES);
                        res_q[g][amp_diag_pkg::RES_OFFSET] <= playMode
                            && offPersist_q[g] && offsetHigh[g];
                    end
                end
            end

            assign diagResults_d[g*RW +: RW] = res_q[g];
        end
    endgenerate

    // Speaker safety routine: check offset after play, mute within window
    logic safetyArmed_q;
    logic [CW-1:0] safeCnt_q;
    logic safetyTrip_q;

    always_ff @(posedge clk) begin
        if (!rst_b || !stbyOut) begin
            safetyArmed_q <= 1'b1;
            safeCnt_q <= '0;
            safetyTrip_q <= 1'b0;
        end else if (safetyEn && playMode && safetyArmed_q) begin
            safetyArmed_q <= 1'b0;
            safeCnt_q <= CW'(SAFETY_CYCLES);
        end else if (safeCnt_q != '0) begin
            safeCnt_q <= dec(safeCnt_q);
            if (|offsetHigh) begin
                safetyTrip_q <= 1'b1;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            channelOn <= '0;
            safetyMute <= 1'b0;
            diagByteTwo <= 8'h00;
            diagResults <= '0;
        end else begin
            channelOn <= safetyTrip_q ? '0 : chOn;
            safetyMute <= safetyTrip_q;
            diagByteTwo <= 8'h00;
            diagByteTwo[amp_diag_pkg::DB2_SAFETY_BIT] <= safetyTrip_q;
            diagResults <= diagResults_d;
        end
    end
endmodule // amp_fault_diag

/* verif/amp_fault_diag_checker.sv */
// Port-level checker of the amplifier diagnostic sequencer
`timescale 1ns/1ps
module amp_fault_diag_checker #(
    parameter int CHANNELS = 4,
    parameter int DIAG_CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hostRead,
    input wire logic playMode,
    input wire logic [CHANNELS-1:0] channelOn,
    input wire logic powerStageOff,
    input wire logic pulseActive,
    input wire logic safetyMute,
    input wire logic [7:0] diagByteTwo,
    input wire logic [CHANNELS*amp_diag_pkg::RES_WIDTH-1:0] diagResults
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic pulseSeen_q, readSeen_q, pulseWas_q;
    int pulseLen_q;
    // Reads between pulses and length of the running pulse
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pulseSeen_q <= 1'b0;
            readSeen_q <= 1'b0;
            pulseWas_q <= 1'b0;
            pulseLen_q <= 0;
        end else begin
            pulseWas_q <= pulseActive;
            pulseLen_q <= pulseActive ? pulseLen_q + 1 : 0;
            if (pulseActive && !pulseWas_q) begin
                pulseSeen_q <= 1'b1;
                readSeen_q <= 1'b0;
            end else if (hostRead) begin
                readSeen_q <= 1'b1;
            end
        end
    end
    // Standby with no pulse and no read for four cycles
    sequence quietStandby;
        (powerStageOff && !pulseActive && !hostRead) [*4];
    endsequence
    sequence pulseStart;
        $rose(pulseActive);
    endsequence
    AST_RESET_VALUES: assert property ($rose(rst_b) |-> powerStageOff && !pulseActive
        && !safetyMute && channelOn == '0 && diagResults == '0) else $error("bad reset outputs");
    AST_PULSE_STAGE_OFF: assert property (pulseActive |-> powerStageOff)
        else $error("stage on during pulse");
    AST_PULSE_OUTPUTS_OFF: assert property (pulseActive |-> channelOn == '0)
        else $error("channel on during pulse");
    AST_PULSE_MIN_LEN: assert property (pulseStart |-> pulseActive [*8])
        else $error("pulse too short");
    AST_PULSE_MAX_LEN: assert property (pulseLen_q <= DIAG_CYCLES + 2)
        else $error("pulse too long");
    AST_PULSE_NEEDS_READ: assert property (pulseStart and pulseSeen_q |-> readSeen_q)
        else $error("pulse without read");
    AST_RESULTS_HELD: assert property (quietStandby |=> $stable(diagResults))
        else $error("results changed while idle");
    AST_SAFETY_REPORTED: assert property ($rose(safetyMute) |-> ##[0:2] diagByteTwo[6])
        else $error("safety flag missing");
    AST_SAFETY_IN_PLAY: assert property ($rose(safetyMute) |-> $past(playMode))
        else $error("safety mute outside play");
endmodule // amp_fault_diag_checker

bind amp_fault_diag amp_fault_diag_checker #(.CHANNELS(CHANNELS), .DIAG_CYCLES(DIAG_CYCLES))
    chk_u (.clk(clk), .rst_b(rst_b), .hostRead(hostRead), .playMode(playMode),
    .channelOn(channelOn), .powerStageOff(powerStageOff), .pulseActive(pulseActive),
    .safetyMute(safetyMute), .diagByteTwo(diagByteTwo), .diagResults(diagResults));

/* verif/host_mcu.sv */
// Host controller model: instruction writes and diagnostic reads
`timescale 1ns/1ps
module host_mcu (
    input wire logic clk,
    output logic [7:0] instructionByteOne,
    output logic [7:0] instructionByteTwo,
    output logic instrWrite,
    output logic hostRead
);
    // Idle values before the first request
    initial begin
        instructionByteOne = 8'h00;
        instructionByteTwo = 8'h00;
        instrWrite = 1'b0;
        hostRead = 1'b0;
    end
    // One-cycle write; standby exit, diag enable and unmute bits go together
    task automatic writeInstr(input logic [7:0] b1, input logic [7:0] b2);
        @(posedge clk);
        instructionByteOne <= b1;
        instructionByteTwo <= b2;
        instrWrite <= 1'b1;
        @(posedge clk);
        instrWrite <= 1'b0;
    endtask
    // One-cycle read strobe closing a measuring period
    task automatic readDiag();
        @(posedge clk);
        hostRead <= 1'b1;
        @(posedge clk);
        hostRead <= 1'b0;
    endtask
endmodule // host_mcu

/* verif/tb.sv */
// Self-checking bench of the amplifier diagnostic sequencer
`timescale 1ns/1ps
module tb;
    localparam int DIAG = 50;
    localparam int CHECK = 10;
    localparam int SAFE = 20;
    localparam int W = amp_diag_pkg::RES_WIDTH;
    localparam int GND = amp_diag_pkg::RES_SHORT_GND;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic playMode = 1'b0;
    logic [3:0] scProtect = 4'h0, shortGnd = 4'h0, offsetHigh = 4'h0, idleLoad = 4'h0;
    logic [3:0] acPulseHigh = 4'h0, acPulseLow = 4'h0, channelOn;
    logic [3:0] loadShortLine = 4'h0;
    logic [7:0] ib1, ib2, diagByteTwo;
    logic instrWrite, hostRead, powerStageOff, pulseActive, safetyMute;
    logic [23:0] diagResults;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    // Clock and cycle ceiling
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end
    host_mcu host_u (.clk(clk), .instructionByteOne(ib1), .instructionByteTwo(ib2),
        .instrWrite(instrWrite), .hostRead(hostRead));
    amp_fault_diag #(.DIAG_CYCLES(DIAG), .CHECK_CYCLES(CHECK), .SAFETY_CYCLES(SAFE)) dut_u (
        .clk(clk), .rst_b(rst_b), .instructionByteOne(ib1), .instructionByteTwo(ib2),
        .instrWrite(instrWrite), .hostRead(hostRead), .playMode(playMode),
        .scProtect(scProtect), .shortGnd(shortGnd), .shortVs(idleLoad),
        .loadShortHigh(idleLoad), .loadShortLine(loadShortLine), .loadOpenHigh(idleLoad),
        .loadOpenLine(idleLoad), .offsetHigh(offsetHigh), .acPulseHigh(acPulseHigh),
        .acPulseLow(acPulseLow), .channelOn(channelOn), .powerStageOff(powerStageOff),
        .pulseActive(pulseActive), .safetyMute(safetyMute), .diagByteTwo(diagByteTwo),
        .diagResults(diagResults));
    // Compare and count
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Bounded wait for the pulse level
    task automatic waitPulse(input logic lvl);
        for (int i = 0; i < DIAG + 10 && pulseActive !== lvl; i++) @(negedge clk);
    endtask
    // Turn-on pulse, held result, refused and re-armed pulse
    task automatic testTurnOn();
        shortGnd <= 4'h2;
        host_u.writeInstr(8'h90, 8'h00);
        waitPulse(1'b1);
        check("pulse", 24'h1, 24'(pulseActive));
        check("stage off", 24'h1, 24'(powerStageOff));
        check("outputs off", 24'h0, 24'(channelOn));
        waitPulse(1'b0);
        repeat (4) @(negedge clk);
        check("gnd ch1", 24'h1 << (W + GND), diagResults);
        @(posedge clk);
        shortGnd <= 4'h0;
        host_u.writeInstr(8'h00, 8'h00);
        host_u.writeInstr(8'h90, 8'h00);
        repeat (10) @(negedge clk);
        check("no pulse", 24'h0, 24'(pulseActive));
        check("held", 24'h1 << (W + GND), diagResults);
        host_u.writeInstr(8'h00, 8'h00);
        host_u.readDiag();
        host_u.writeInstr(8'hD8, 8'h00);
        waitPulse(1'b1);
        check("new pulse", 24'h1, 24'(pulseActive));
        waitPulse(1'b0);
        repeat (4) @(negedge clk);
        check("fresh", 24'h0, diagResults);
        $display("test turn_on done");
    endtask
    // Permanent diagnostics: spike, lasting short, restart
    task automatic testPermanent();
        playMode <= 1'b1;
        repeat (5) @(negedge clk);
        check("all on", 24'hF, 24'(channelOn));
        @(posedge clk);
        scProtect <= 4'h4;
        repeat (3) @(posedge clk);
        scProtect <= 4'h0;
        repeat (CHECK + 5) @(negedge clk);
        check("resume", 24'hF, 24'(channelOn));
        check("no diag", 24'h0, diagResults);
        @(posedge clk);
        scProtect <= 4'h4;
        shortGnd <= 4'h4;
        loadShortLine <= 4'h4;
        repeat (CHECK + DIAG / 2) @(negedge clk);
        check("running", 24'h0, diagResults);
        repeat (DIAG / 2 + 10) @(negedge clk);
        check("restart", 24'hB, 24'(channelOn));
        check("short ch2", 24'h5 << (2 * W + GND), diagResults);
        @(posedge clk);
        scProtect <= 4'h0;
        shortGnd <= 4'h0;
        loadShortLine <= 4'h0;
        repeat (2 * CHECK + 5) @(negedge clk);
        check("restarted", 24'hF, 24'(channelOn));
        check("kept", 24'h5 << (2 * W + GND), diagResults);
        @(posedge clk);
        scProtect <= 4'h4;
        repeat (CHECK + DIAG + 5) @(negedge clk);
        check("no second cycle", 24'h5 << (2 * W + GND), diagResults);
        check("restart only", 24'hB, 24'(channelOn));
        @(posedge clk);
        scProtect <= 4'h0;
        repeat (2 * CHECK + 5) @(negedge clk);
        check("back on", 24'hF, 24'(channelOn));
        $display("test permanent done");
    endtask
    // AC tweeter check over enables, thresholds and pulse counts
    task automatic testAc();
        logic [7:0] b2[6] = '{8'h04, 8'h04, 8'h00, 8'h84, 8'h84, 8'h04};
        int n[6] = '{2, 3, 0, 2, 3, 3};
        logic [5:0] useLow = 6'h38;
        logic [5:0] expOpen = 6'h29;
        for (int i = 0; i < 6; i++) begin
            host_u.writeInstr(8'h86, b2[i]);
            for (int k = 0; k < n[i]; k++) begin
                @(posedge clk);
                acPulseHigh <= useLow[i] ? 4'h0 : 4'h1;
                acPulseLow <= useLow[i] ? 4'h1 : 4'h0;
                @(posedge clk);
                acPulseHigh <= 4'h0;
                acPulseLow <= 4'h0;
            end
            host_u.readDiag();
            repeat (4) @(negedge clk);
            check("ac open", 24'(expOpen[i]), 24'(diagResults[amp_diag_pkg::RES_AC_OPEN]));
        end
        host_u.writeInstr(8'h86, 8'h04);
        @(posedge clk);
        scProtect <= 4'h1;
        @(posedge clk);
        scProtect <= 4'h0;
        host_u.readDiag();
        repeat (4) @(negedge clk);
        check("ac suppressed", 24'h0, 24'(diagResults[amp_diag_pkg::RES_AC_OPEN]));
        $display("test ac done");
    endtask
    // Safety routine with and without enable, then offset report
    task automatic testSafety();
        playMode <= 1'b0;
        offsetHigh <= 4'h1;
        host_u.writeInstr(8'h00, 8'h01);
        host_u.writeInstr(8'h80, 8'h01);
        playMode <= 1'b1;
        for (int i = 0; i < SAFE + 5 && safetyMute !== 1'b1; i++) @(negedge clk);
        check("mute", 24'h1, 24'(safetyMute));
        check("flag", 24'h1, 24'(diagByteTwo[amp_diag_pkg::DB2_SAFETY_BIT]));
        @(posedge clk);
        playMode <= 1'b0;
        host_u.writeInstr(8'h00, 8'h00);
        host_u.writeInstr(8'hA0, 8'h00);
        playMode <= 1'b1;
        repeat (SAFE + 5) @(negedge clk);
        check("no mute", 24'h0, 24'(safetyMute));
        host_u.readDiag();
        repeat (4) @(negedge clk);
        check("offset", 24'h1, 24'(diagResults[amp_diag_pkg::RES_OFFSET]));
        $display("test safety done");
    endtask
    // Counts, verdict and end of run
    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Reset, then the scenarios in order
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        check("reset stage", 24'h1, 24'(powerStageOff));
        @(posedge clk);
        testTurnOn();
        @(posedge clk);
        testPermanent();
        testAc();
        @(posedge clk);
        testSafety();
        summarize();
    end
endmodule // tb
